// *** hdl/tal_alarm_top.sv ***
// Limit comparison, alarm filtering, over-temperature outputs and the two-wire slave register port.
// Assumes measurements arrive as one-cycle strobes on ref_clk; SCL and SDA are asynchronous pins.
`include "tal_regs.svh"

module tal_alarm_top
    import tal_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h4C,
    parameter logic [7:0] MAKER_ID = 8'h5A,      // Arbitrary value
    parameter logic [7:0] REVISION = 8'h01,      // Arbitrary value
    parameter int TIMEOUT_CYCLES = `TAL_TIMEOUT_MS * `TAL_REF_CLK_KHZ
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Measurement path
    input wire logic meas_valid,
    input wire logic [7:0] meas_value,
    input wire logic conv_busy,
    output logic oneshot_start,
    output logic standby,
    output logic range_ext,
    output logic [7:0] conv_rate,
    // Alarm pins
    output logic alarm_out,
    output logic alarm_oe,
    output logic overtemp_out_n
);
    localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    logic scl_rise, scl_fall, start_det, stop_det, timeout_hit;
    logic [TO_W-1:0] to_cnt;
    tal_bus_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shreg, pointer, rx_byte, rd_data, wr_addr, wr_data;
    logic rw, is_ara, first_byte, wr_strobe, status_read, ara_done;
    logic [7:0] configuration, conversion_rate, high_temp_limit, low_temp_limit;
    logic [7:0] overtemp_limit, overtemp_hysteresis, consecutive_count, temperature_value;
    logic [7:0] ot_release, fan_release;
    logic [2:0] viol_cnt, viol_need;
    logic flag_high, flag_low, critical_flag, alert_active, limit_now, fan_trip_out_n;
    logic out_hi, out_lo;

    // Two-stage synchronisers; only the second stage feeds edge detection
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            {scl_s1, scl_s2, scl_d} <= 3'h7;
            {sda_s1, sda_s2, sda_d} <= 3'h7;
        end
        else
        begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    assign scl_rise = scl_s2 & ~scl_d;
    assign scl_fall = ~scl_s2 & scl_d;
    assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
    assign rx_byte = {shreg[6:0], sda_s2};

    // Silence on a busy bus is counted; any pin edge restarts the count
    always_ff @(posedge ref_clk)
    begin
        if (rst || !consecutive_count[`TAL_CONSEC_TO_BIT] || state == BUS_IDLE || (scl_s2 != scl_d)
            || (sda_s2 != sda_d))
            to_cnt <= '0;
        else
            to_cnt <= to_cnt + 1'b1;
    end
    assign timeout_hit = (to_cnt == TO_W'(TIMEOUT_CYCLES - 1));

    always_comb
    begin
        case (pointer)
            `TAL_RD_TEMP: rd_data = temperature_value;
            `TAL_RD_STATUS: rd_data = {conv_busy, flag_high, flag_low, 4'h0, critical_flag};
            `TAL_RD_CONFIG: rd_data = configuration;
            `TAL_RD_RATE: rd_data = conversion_rate;
            `TAL_RD_HIGH: rd_data = high_temp_limit;
            `TAL_RD_LOW: rd_data = low_temp_limit;
            `TAL_RW_OT_LIMIT: rd_data = overtemp_limit;
            `TAL_RW_OT_HYST: rd_data = overtemp_hysteresis;
            `TAL_RW_CONSEC: rd_data = consecutive_count;
            `TAL_RD_MAKER: rd_data = MAKER_ID;
            `TAL_RD_REV: rd_data = REVISION;
            default: rd_data = 8'h00;
        endcase
    end

    // Slave-only bus engine; it never starts a transfer of its own
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state <= BUS_IDLE;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            pointer <= 8'h00;
            rw <= 1'b0;
            is_ara <= 1'b0;
            first_byte <= 1'b0;
            wr_strobe <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            status_read <= 1'b0;
            ara_done <= 1'b0;
        end
        else
        begin
            wr_strobe <= 1'b0;
            status_read <= 1'b0;
            ara_done <= 1'b0;
            if (timeout_hit)
            begin
                state <= BUS_IDLE;
                sda_oe <= 1'b0;
            end
            else if (start_det)
            begin
                state <= BUS_ADDR;
                bit_cnt <= 3'h0;
                sda_oe <= 1'b0;
                first_byte <= 1'b1;
            end
            else if (stop_det)
            begin
                state <= BUS_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (state)
                    BUS_IDLE: ;
                    BUS_ADDR:
                        if (scl_rise)
                        begin
                            shreg <= rx_byte;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7)
                            begin
                                rw <= sda_s2;
                                is_ara <= (rx_byte[7:1] == `TAL_ALERT_RESP_ADDR);
                                if (rx_byte[7:1] == SLAVE_ADDR)
                                    state <= BUS_ADDR_ACK;
                                else if (rx_byte[7:1] == `TAL_ALERT_RESP_ADDR && sda_s2 && alert_active)
                                    state <= BUS_ADDR_ACK;
                                else
                                    state <= BUS_IDLE;
                            end
                        end
                    BUS_ADDR_ACK:
                        if (scl_fall)
                        begin
                            if (!sda_oe)
                                sda_oe <= 1'b1;
                            else if (rw)
                            begin
                                shreg <= is_ara ? {SLAVE_ADDR, 1'b1} : rd_data;
                                sda_oe <= is_ara ? ~SLAVE_ADDR[6] : ~rd_data[7];
                                bit_cnt <= 3'h0;
                                state <= BUS_TX;
                            end
                            else
                            begin
                                sda_oe <= 1'b0;
                                bit_cnt <= 3'h0;
                                state <= BUS_RX;
                            end
                        end
                    BUS_RX:
                        if (scl_rise)
                        begin
                            shreg <= rx_byte;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7)
                            begin
                                state <= BUS_RX_ACK;
                                first_byte <= 1'b0;
                                if (first_byte)
                                    pointer <= rx_byte;
                                else
                                begin
                                    wr_strobe <= 1'b1;
                                    wr_addr <= pointer;
                                    wr_data <= rx_byte;
                                end
                            end
                        end
                    BUS_RX_ACK:
                        if (scl_fall)
                        begin
                            sda_oe <= ~sda_oe;
                            if (sda_oe)
                                state <= BUS_RX;
                        end
                    BUS_TX:
                        if (scl_rise)
                        begin
                            bit_cnt <= bit_cnt + 3'h1;
                            if (shreg[7] && !sda_s2)
                            begin
                                state <= BUS_IDLE;
                                sda_oe <= 1'b0;
                            end
                        end
                        else if (scl_fall)
                        begin
                            if (bit_cnt == 3'h0)
                            begin
                                sda_oe <= 1'b0;
                                state <= BUS_TX_ACK;
                                ara_done <= is_ara;
                                status_read <= !is_ara && pointer == `TAL_RD_STATUS;
                            end
                            else
                            begin
                                shreg <= {shreg[6:0], 1'b0};
                                sda_oe <= ~shreg[6];
                            end
                        end
                    BUS_TX_ACK:
                        if (scl_rise)
                        begin
                            shreg <= is_ara ? {SLAVE_ADDR, 1'b1} : rd_data;
                            state <= sda_s2 ? BUS_IDLE : BUS_TX_LOAD;
                        end
                    BUS_TX_LOAD:
                        if (scl_fall)
                        begin
                            sda_oe <= ~shreg[7];
                            bit_cnt <= 3'h0;
                            state <= BUS_TX;
                        end
                    default: state <= BUS_IDLE;
                endcase
            end
        end
    end

    // Register writes; read-only and unknown addresses drop the data
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            configuration <= `TAL_RST_CONFIG;
            conversion_rate <= `TAL_RST_RATE;
            high_temp_limit <= `TAL_RST_HIGH;
            low_temp_limit <= `TAL_RST_LOW;
            overtemp_limit <= `TAL_RST_OT_LIMIT;
            overtemp_hysteresis <= `TAL_RST_OT_HYST;
            consecutive_count <= `TAL_RST_CONSEC;
            oneshot_start <= 1'b0;
        end
        else
        begin
            oneshot_start <= wr_strobe && wr_addr == `TAL_WR_ONESHOT
                             && configuration[`TAL_CFG_STANDBY_BIT];
            if (wr_strobe)
            begin
                case (wr_addr)
                    `TAL_WR_CONFIG: configuration <= wr_data;
                    `TAL_WR_RATE: conversion_rate <= wr_data;
                    `TAL_WR_HIGH: high_temp_limit <= wr_data;
                    `TAL_WR_LOW: low_temp_limit <= wr_data;
                    `TAL_RW_OT_LIMIT: overtemp_limit <= wr_data;
                    `TAL_RW_OT_HYST: overtemp_hysteresis <= wr_data;
                    `TAL_RW_CONSEC: consecutive_count <= wr_data;
                    default: ;
                endcase
            end
        end
    end

    assign standby = configuration[`TAL_CFG_STANDBY_BIT];
    assign range_ext = configuration[`TAL_CFG_RANGE_BIT];
    assign conv_rate = conversion_rate;

    // Both ranges are monotonic unsigned codes, so one comparator serves both
    assign out_hi = meas_value > high_temp_limit;
    assign out_lo = meas_value < low_temp_limit;
    // Unlisted patterns take the highest set bit of the field
    assign viol_need = consecutive_count[3] ? 3'h4 : consecutive_count[2] ? 3'h3 :
                       consecutive_count[1] ? 3'h2 : 3'h1;
    assign ot_release = (overtemp_limit > overtemp_hysteresis) ? overtemp_limit - overtemp_hysteresis : 8'h00;
    assign fan_release = (high_temp_limit > overtemp_hysteresis) ? high_temp_limit - overtemp_hysteresis : 8'h00;

    // Violation run filter and alarm latch
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            temperature_value <= `TAL_RST_TEMP;
            viol_cnt <= 3'h0;
            limit_now <= 1'b0;
            alert_active <= 1'b0;
        end
        else
        begin
            if (ara_done && !limit_now)
                alert_active <= 1'b0;
            if (meas_valid)
            begin
                temperature_value <= meas_value;
                limit_now <= out_hi | out_lo;
                if (out_hi | out_lo)
                begin
                    if (viol_cnt < viol_need)
                        viol_cnt <= viol_cnt + 3'h1;
                    if (viol_cnt + 3'h1 >= viol_need)
                        alert_active <= 1'b1;
                end
                else
                    viol_cnt <= 3'h0;
            end
        end
    end

    // Sticky status flags; a trip in the read cycle survives the clear
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            flag_high <= 1'b0;
            flag_low <= 1'b0;
            critical_flag <= 1'b0;
        end
        else
        begin
            flag_high <= (flag_high & ~status_read) | (meas_valid & out_hi);
            flag_low <= (flag_low & ~status_read) | (meas_valid & out_lo);
            critical_flag <= (critical_flag & ~status_read) | (meas_valid & (meas_value > overtemp_limit));
        end
    end

    // Over-temperature outputs with hysteresis; fan trip uses the high limit
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            overtemp_out_n <= 1'b1;
            fan_trip_out_n <= 1'b1;
        end
        else if (meas_valid)
        begin
            if (meas_value > overtemp_limit)
                overtemp_out_n <= 1'b0;
            else if (meas_value <= ot_release)
                overtemp_out_n <= 1'b1;
            if (meas_value > high_temp_limit)
                fan_trip_out_n <= 1'b0;
            else if (meas_value <= fan_release)
                fan_trip_out_n <= 1'b1;
        end
    end

    // Shared pin is open-drain only, so several devices can share one line
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            alarm_out <= 1'b0;
            alarm_oe <= 1'b0;
        end
        else
        begin
            alarm_out <= 1'b0;
            if (configuration[`TAL_CFG_PINSEL_BIT])
                alarm_oe <= ~fan_trip_out_n;
            else
                alarm_oe <= alert_active & ~configuration[`TAL_CFG_MASK_BIT];
        end
    end
endmodule // tal_alarm_top

// *** hdl/tal_pkg.sv ***
// Types shared by the temperature alarm block.
// Assumes tal_regs.svh is on the include path.
package tal_pkg;
    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ADDR_ACK,
        BUS_RX,
        BUS_RX_ACK,
        BUS_TX,
        BUS_TX_ACK,
        BUS_TX_LOAD
    } tal_bus_state_t;
endpackage

// *** hdl/tal_regs.svh ***
// Register offsets, reset values and timing figures of the temperature alarm block.
// Assumes inclusion by bare name from the top module.
`ifndef TAL_REGS_SVH
`define TAL_REGS_SVH
`define TAL_RD_TEMP 8'h00
`define TAL_RD_STATUS 8'h02
`define TAL_RD_CONFIG 8'h03
`define TAL_RD_RATE 8'h04
`define TAL_RD_HIGH 8'h05
`define TAL_RD_LOW 8'h06
`define TAL_WR_CONFIG 8'h09
`define TAL_WR_RATE 8'h0A
`define TAL_WR_HIGH 8'h0B
`define TAL_WR_LOW 8'h0C
`define TAL_WR_ONESHOT 8'h0F
`define TAL_RW_OT_LIMIT 8'h20
`define TAL_RW_OT_HYST 8'h21
`define TAL_RW_CONSEC 8'h22
`define TAL_RD_MAKER 8'hFE
`define TAL_RD_REV 8'hFF
`define TAL_RST_CONFIG 8'h00
`define TAL_RST_RATE 8'h08
`define TAL_RST_HIGH 8'h55
`define TAL_RST_LOW 8'h00
`define TAL_RST_OT_LIMIT 8'h55
`define TAL_RST_OT_HYST 8'h0A
`define TAL_RST_CONSEC 8'h01
`define TAL_RST_TEMP 8'h00
`define TAL_CFG_MASK_BIT 7
`define TAL_CFG_STANDBY_BIT 6
`define TAL_CFG_PINSEL_BIT 5
`define TAL_CFG_RANGE_BIT 2
`define TAL_CONSEC_TO_BIT 7
`define TAL_ST_BUSY_BIT 7
`define TAL_ST_HIGH_BIT 6
`define TAL_ST_LOW_BIT 5
`define TAL_ST_CRIT_BIT 0
`define TAL_ALERT_RESP_ADDR 7'h0C
`define TAL_TIMEOUT_MS 25
`define TAL_REF_CLK_KHZ 40000
`endif

// *** sim/tal_alarm_chk.sv ***
// Port checks of the temperature alarm block.
// Assumes one clock domain, ref_clk, and a synchronous active-high rst.
module tal_alarm_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Measurement path
    input wire logic meas_valid,
    input wire logic [7:0] meas_value,
    input wire logic oneshot_start,
    input wire logic standby,
    input wire logic [7:0] conv_rate,
    // Alarm pins
    input wire logic alarm_out,
    input wire logic alarm_oe,
    input wire logic overtemp_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    a_alarm_open_drain: assert property (alarm_oe |-> !alarm_out)
        else $error("Alarm pin driven high");
    a_sda_open_drain: assert property (sda_oe |-> !sda_out)
        else $error("Data pin driven high");
    // A rise needs a fresh result two cycles back; one cycle of slack allows three
    a_alarm_after_meas: assert property ($rose(alarm_oe) |-> $past(meas_valid, 2) || $past(meas_valid, 3))
        else $error("Alarm rose without a result");
    a_ot_trip_max: assert property (meas_valid && meas_value == 8'hFF |=> !overtemp_out_n)
        else $error("Overtemp missed full-scale result");
    a_ot_release_zero: assert property (meas_valid && meas_value == 8'h00 |=> overtemp_out_n)
        else $error("Overtemp held at zero result");
    a_ot_meas_only: assert property ($changed(overtemp_out_n) |-> $past(meas_valid))
        else $error("Overtemp moved without a result");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in || !$past(scl_in))
        else $error("Data changed while clock high");
    a_oneshot_pulse: assert property (oneshot_start |-> standby ##1 !oneshot_start)
        else $error("Single conversion pulse wrong");
    a_reset_idle: assert property (disable iff (1'b0) rst |=> !sda_oe && !alarm_oe && overtemp_out_n)
        else $error("Outputs not idle after reset");
    a_reset_rate: assert property (disable iff (1'b0) rst |=> conv_rate == 8'h08)
        else $error("Rate not at reset value");
endmodule // tal_alarm_chk

bind tal_alarm_top tal_alarm_chk u_chk (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .meas_valid(meas_valid),
    .meas_value(meas_value), .oneshot_start(oneshot_start), .standby(standby), .conv_rate(conv_rate),
    .alarm_out(alarm_out), .alarm_oe(alarm_oe), .overtemp_out_n(overtemp_out_n));

// *** sim/tal_alarm_top_bench.sv ***
// Self-checking bench of the temperature alarm block.
// Assumes the master model on the bus and results strobed in by the bench.
module tal_alarm_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
    localparam logic [7:0] REV = 8'h07; // Arbitrary value
    typedef struct {logic [7:0] cnt; int n; logic [7:0] val; logic exp;} tal_row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic meas_valid = 1'b0;
    logic [7:0] meas_value = 8'h00;
    logic scl, sda_m, sda_out, sda_oe, oneshot_start, standby, range_ext, alarm_out, alarm_oe, overtemp_out_n, ok;
    logic [7:0] conv_rate, d;
    wire logic sda_line = sda_m & ~sda_oe;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int shots = 0;
    logic [15:0] rst_vals [10] = '{16'h0000, 16'h0300, 16'h0408, 16'h0555, 16'h0600, 16'h2055, 16'h210A,
        16'h2201, {8'hFE, MAKER}, {8'hFF, REV}};
    // Result runs against the count field; the low limit is raised to 0x10 first
    tal_row_t rows [9] = '{'{8'h01, 1, 8'hFF, 1'b1}, '{8'h02, 1, 8'h60, 1'b0}, '{8'h02, 2, 8'h60, 1'b1},
        '{8'h06, 2, 8'h60, 1'b0}, '{8'h06, 3, 8'h60, 1'b1}, '{8'h0E, 3, 8'h60, 1'b0},
        '{8'h0E, 4, 8'h60, 1'b1}, '{8'h70, 1, 8'h05, 1'b1}, '{8'h01, 1, 8'h55, 1'b0}};
    logic [7:0] broken [5] = '{8'h60, 8'h60, 8'h30, 8'h60, 8'h60};
    tal_alarm_top #(.MAKER_ID(MAKER), .REVISION(REV), .TIMEOUT_CYCLES(200)) DUT (
        .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .meas_valid(meas_valid), .meas_value(meas_value), .conv_busy(1'b0), .oneshot_start(oneshot_start),
        .standby(standby), .range_ext(range_ext), .conv_rate(conv_rate), .alarm_out(alarm_out),
        .alarm_oe(alarm_oe), .overtemp_out_n(overtemp_out_n));
    tal_i2c_master M (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
    always #12.5 ref_clk = ~ref_clk;
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        if (got !== exp)
            fail_count++;
    endtask
    // Three quiet cycles let the alarm outputs settle before any check
    task automatic meas(input logic [7:0] v);
        meas_value <= v;
        meas_valid <= 1'b1;
        @(posedge ref_clk);
        meas_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    // Stall with SCL low while the slave drives a 0 data bit
    task automatic stall(input logic exp);
        M.rd_reg(8'h05, d);
        M.start_c();
        M.xfer(8'h99, 1'b1, d, ok);
        M.drv(1'b0, 1'b1, 250);
        chk(8'(sda_oe), 8'(exp));
        M.xfer(8'hFF, 1'b1, d, ok);
        M.stop_c();
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (oneshot_start === 1'b1)
            shots++;
        if (cycles == 40000)
        begin
            fail_count++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        foreach (rst_vals[i])
        begin
            M.rd_reg(rst_vals[i][15:8], d);
            chk(d, rst_vals[i][7:0]);
        end
        M.wr_reg(8'h0C, 8'h10, ok);
        foreach (rows[i])
        begin
            M.wr_reg(8'h22, rows[i].cnt, ok);
            M.rd_reg(8'h22, d);
            chk(d, rows[i].cnt);
            repeat (rows[i].n) meas(rows[i].val);
            chk(8'(alarm_oe), 8'(rows[i].exp));
            chk(8'(overtemp_out_n), 8'(rows[i].val <= 8'h55));
            meas(8'h30);
            if (rows[i].exp)
                M.ara(8'hFF, d);
            if (rows[i].exp)
                chk(d, 8'h99);
            chk(8'(alarm_oe), 8'h00);
        end
        M.wr_reg(8'h22, 8'h06, ok);
        foreach (broken[i]) meas(broken[i]);
        chk(8'(alarm_oe), 8'h00);
        M.wr_reg(8'h22, 8'h01, ok);
        M.rd_reg(8'h02, d);
        meas(8'h60);
        M.ara(8'hFF, d);
        chk(d, 8'h99);
        chk(8'(alarm_oe), 8'h01);
        meas(8'h4C);
        chk(8'(overtemp_out_n), 8'h00);
        // A lower-addressed rival wins the answer; the loser keeps its alarm and retries
        M.ara(8'h91, d);
        chk(d, 8'h91);
        chk(8'(alarm_oe), 8'h01);
        M.ara(8'hFF, d);
        chk(d, 8'h99);
        chk(8'(alarm_oe), 8'h00);
        meas(8'h4B);
        chk(8'(overtemp_out_n), 8'h01);
        M.rd_reg(8'h02, d);
        chk(d, 8'h41);
        M.rd_reg(8'h02, d);
        chk(d, 8'h00);
        M.wr_reg(8'h00, 8'hAA, ok);
        chk(8'(ok), 8'h01);
        M.rd_reg(8'h00, d);
        chk(d, 8'h4B);
        M.wr_reg(8'h09, 8'h44, ok);
        M.wr_reg(8'h0F, 8'h5A, ok);
        chk(8'({standby, range_ext}), 8'h03);
        M.wr_reg(8'h0A, 8'h05, ok);
        M.wr_reg(8'h09, 8'h00, ok);
        M.wr_reg(8'h0F, 8'h5A, ok);
        chk(8'(shots), 8'h01);
        chk(conv_rate, 8'h05);
        stall(1'b1);
        M.wr_reg(8'h22, 8'h81, ok);
        M.slow = 3;
        stall(1'b0);
        M.rd_reg(8'h22, d);
        chk(d, 8'h81);
        M.wr_reg(8'h09, 8'h20, ok);
        meas(8'h60);
        chk(8'(alarm_oe), 8'h01);
        meas(8'h00);
        chk(8'(alarm_oe), 8'h00);
        // Reset in mid-run with the pin, the output and the flags all active
        meas(8'h60);
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk(8'({alarm_oe, overtemp_out_n}), 8'h01);
        M.rd_reg(8'h22, d);
        chk(d, 8'h01);
        M.rd_reg(8'h02, d);
        chk(d, 8'h00);
        print_verdict();
    end
endmodule // tal_alarm_top_bench

// *** sim/tal_i2c_master.sv ***
// Two-wire bus master model: SCL and an open-drain SDA, eight ref_clk cycles a bit plus slow in the low phase.
// Assumes the bench resolves SDA with a pull-up and returns the wire on sda_line.
module tal_i2c_master #(
    parameter logic [6:0] DEV_ADDR = 7'h4C
)
(
    // Clock
    input wire logic ref_clk,
    // Bus
    input wire logic sda_line,
    output logic scl,
    output logic sda_m
);
    timeunit 1ns;
    timeprecision 1ps;
    int slow = 0;
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic drv(input logic c, input logic s, input int n);
        scl <= c;
        sda_m <= s;
        repeat (n) @(posedge ref_clk);
    endtask
    // Sample at the end of the high phase; the slave only moves SDA after a fall
    task automatic bit_io(input logic b, output logic r);
        drv(1'b0, sda_m, 1);
        drv(1'b0, b, 3 + slow);
        drv(1'b1, b, 4);
        r = sda_line;
    endtask
    task automatic start_c();
        drv(1'b0, 1'b1, 4);
        drv(1'b1, 1'b1, 4);
        drv(1'b1, 1'b0, 4);
    endtask
    task automatic stop_c();
        drv(1'b0, 1'b0, 4);
        drv(1'b1, 1'b0, 4);
        drv(1'b1, 1'b1, 4);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(mack, ack);
    endtask
    task automatic wr_reg(input logic [7:0] p, input logic [7:0] v, output logic ok);
        logic [7:0] r;
        logic a0, a1, a2;
        start_c();
        xfer({DEV_ADDR, 1'b0}, 1'b1, r, a0);
        xfer(p, 1'b1, r, a1);
        xfer(v, 1'b1, r, a2);
        stop_c();
        ok = !(a0 | a1 | a2);
    endtask
    task automatic rd_reg(input logic [7:0] p, output logic [7:0] v);
        logic [7:0] r;
        logic a;
        start_c();
        xfer({DEV_ADDR, 1'b0}, 1'b1, r, a);
        xfer(p, 1'b1, r, a);
        start_c();
        xfer({DEV_ADDR, 1'b1}, 1'b1, r, a);
        xfer(8'hFF, 1'b1, v, a);
        stop_c();
    endtask
    // A rival byte other than FF stands for a second device answering on the wired line
    task automatic ara(input logic [7:0] rival, output logic [7:0] v);
        logic [7:0] r;
        logic a;
        start_c();
        xfer({7'h0C, 1'b1}, 1'b1, r, a);
        xfer(rival, 1'b1, v, a);
        stop_c();
    endtask
endmodule // tal_i2c_master
